/* File: rtl/sat_defs.vh */
// constants for the segment address translation block
`ifndef SAT_DEFS_VH
`define SAT_DEFS_VH

// ------------------------------------------------------------
// operating modes
// ------------------------------------------------------------
`define SAT_MODE_REAL 2'h0
`define SAT_MODE_PROT 2'h1
`define SAT_MODE_V86 2'h2
`define SAT_MODE_LONG 2'h3

// ------------------------------------------------------------
// user segment register encodings
// ------------------------------------------------------------
`define SAT_SEG_EXTRA 3'h0
`define SAT_SEG_CODE 3'h1
`define SAT_SEG_STACK 3'h2
`define SAT_SEG_DEFDATA 3'h3
`define SAT_SEG_AUXF 3'h4
`define SAT_SEG_AUXG 3'h5
`define SAT_SEG_COUNT 6

// ------------------------------------------------------------
// system segment register encodings
// ------------------------------------------------------------
`define SAT_SYS_GLOBAL 2'h0
`define SAT_SYS_LOCAL 2'h1
`define SAT_SYS_VECTOR 2'h2
`define SAT_SYS_TASK 2'h3

// ------------------------------------------------------------
// selector fields
// ------------------------------------------------------------
`define SAT_SEL_INDEX_MSB 15
`define SAT_SEL_INDEX_LSB 3
`define SAT_SEL_TABLE_BIT 2
`define SAT_SEL_REAL_SHIFT 4

// ------------------------------------------------------------
// table entry sizes as shift counts
// ------------------------------------------------------------
`define SAT_DESC_SHIFT 3'h3
`define SAT_VEC_SHIFT_REAL 3'h2
`define SAT_VEC_SHIFT_PROT 3'h3
`define SAT_VEC_SHIFT_LONG 3'h4

// ------------------------------------------------------------
// attribute fields
// ------------------------------------------------------------
`define SAT_ATTR_DPL_LSB 5
`define SAT_ATTR_DPL_MSB 6
`define SAT_ATTR_L_BIT 9
`define SAT_ATTR_D_BIT 10

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SAT_RST_SEL 16'h0000
`define SAT_RST_BASE 64'h0000_0000_0000_0000
`define SAT_RST_LIMIT 32'h0000_ffff
`define SAT_RST_ATTR 12'h093
`define SAT_RST_TBL_LIMIT 32'h0000_ffff

`endif

/* File: rtl/sat_desc_addr.v */
// table entry address and bound check for descriptor and vector lookups
`timescale 1ns/100ps
`default_nettype none

module sat_desc_addr (
    input wire [63:0] tbl_base_i,
    input wire [31:0] tbl_limit_i,
    input wire [12:0] index_i,
    input wire [2:0] entry_shift_i,
    output wire [63:0] addr_o,
    output wire oob_o
);

    wire [31:0] off_w;
    wire [31:0] span_w;
    wire [32:0] last_w;

    // index scaled by entry size
    assign off_w = {19'h0, index_i} << entry_shift_i;
    assign span_w = (32'h1 << entry_shift_i) - 32'h1;
    assign last_w = {1'b0, off_w} + {1'b0, span_w};
    // whole entry must sit inside the table
    assign oob_o = last_w > {1'b0, tbl_limit_i};
    assign addr_o = tbl_base_i + {32'h0, off_w};

endmodule
`default_nettype wire

/* File: rtl/sat_lin_addr.v */
// linear address formation and limit check per operating regime
`timescale 1ns/100ps
`default_nettype none

module sat_lin_addr (
    input wire real_i,
    input wire flat64_i,
    input wire keep_base_i,
    input wire [63:0] base_i,
    input wire [31:0] limit_i,
    input wire [63:0] off_i,
    output reg [63:0] addr_o,
    output reg fault_o
);

    reg [19:0] sum20;
    reg [31:0] sum32;

    always @* begin
        sum20 = base_i[19:0] + {4'h0, off_i[15:0]};
        sum32 = base_i[31:0] + off_i[31:0];
        addr_o = 64'h0;
        fault_o = 1'b0;
        if (real_i) begin
            // 20-bit physical address, wraps at one megabyte
            addr_o = {44'h0, sum20};
        end else if (flat64_i) begin
            // base treated as zero except the two auxiliary segments
            addr_o = keep_base_i ? (base_i + off_i) : off_i;
        end else begin
            // confined to the low 4 gigabytes
            addr_o = {32'h0, sum32};
            fault_o = (off_i[63:32] != 32'h0) || (off_i[31:0] > limit_i);
        end
    end

endmodule
`default_nettype wire

/* File: rtl/sat_seg_xlate.v */
// segment translation top: user and system segment registers, modes, lookups
//
// Behaviour
// - reset leaves the block in real mode; v86 and long mode entered only from a mode other than real
// - real mode address is selector shifted left four plus 16-bit offset, 20 bits
// - real mode segment load sets selector and base selector times sixteen
// - real mode far transfer loads code selector and base selector times sixteen
// - real mode never consults global table, local table or task segment
// - virtual-8086 loads and far transfers behave as real mode, 1MB space
// - interrupt in virtual-8086 mode switches the block to protected mode
// - protected and compatibility segments carry own base and limit, up to 4G
// - compatibility addressing follows legacy rules within lowest 4 gigabytes
// - 64-bit mode treats code, stack, data and extra bases as zero and ignores limits and non-code attributes
// - 64-bit mode uses code privilege, operand size and wide execution bits
// - 64-bit mode honours non-zero bases of the two auxiliary segments
// - system segment registers stay in use in protected, compatibility and 64-bit modes
// - six user and four system segment registers, each base and limit; user ones also attributes
// - selector load in protected modes fetches descriptor into hidden portion
// - descriptors located via global or local table; vector table by vector
// - table registers hold location and size and bound every lookup
// - task state pointer holds location and limit of task state segment
// - descriptor address is selector index times eight plus table base
// - table select bit zero picks global table, one picks local table
`timescale 1ns/100ps
`default_nettype none
`include "sat_defs.vh"

module sat_seg_xlate (
    input wire core_clk_i,
    input wire rst_i,
    // mode control
    input wire mode_set_valid_i,
    input wire [1:0] mode_set_i,
    input wire intr_i,
    output wire [1:0] mode_o,
    output wire mode_64_o,
    output wire [1:0] cpl_o,
    output wire def_opsize_o,
    output reg mode_err_o,
    // segment loads and far transfers
    input wire seg_ld_valid_i,
    input wire [2:0] seg_ld_idx_i,
    input wire seg_ld_far_i,
    input wire [15:0] seg_ld_sel_i,
    output wire seg_ld_ready_o,
    output reg seg_ld_fault_o,
    // descriptor fetch
    output reg desc_req_valid_o,
    output reg [63:0] desc_req_addr_o,
    input wire desc_rsp_valid_i,
    input wire [31:0] desc_rsp_base_i,
    input wire [31:0] desc_rsp_limit_i,
    input wire [11:0] desc_rsp_attr_i,
    // auxiliary base writes
    input wire aux_base_wr_valid_i,
    input wire aux_base_wr_g_i,
    input wire [63:0] aux_base_wr_data_i,
    // system segment register writes
    input wire sys_wr_valid_i,
    input wire [1:0] sys_wr_sel_i,
    input wire [63:0] sys_wr_base_i,
    input wire [31:0] sys_wr_limit_i,
    input wire [15:0] sys_wr_selector_i,
    output wire [63:0] task_base_o,
    output wire [31:0] task_limit_o,
    output wire [15:0] task_sel_o,
    output wire [15:0] local_sel_o,
    // vector lookups
    input wire vec_valid_i,
    input wire [7:0] vec_i,
    output reg vec_rsp_valid_o,
    output reg [63:0] vec_addr_o,
    output reg vec_fault_o,
    // address requests
    input wire acc_valid_i,
    input wire [2:0] acc_seg_i,
    input wire [63:0] acc_off_i,
    output reg acc_valid_o,
    output reg [63:0] acc_addr_o,
    output reg acc_fault_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [63:0] real_base;
        input [15:0] sel;
        begin
            real_base = {44'h0, sel, 4'h0};
        end
    endfunction

    function is_aux;
        input [2:0] idx;
        begin
            is_aux = (idx == `SAT_SEG_AUXF) || (idx == `SAT_SEG_AUXG);
        end
    endfunction

    localparam ST_IDLE = 1'b0;
    localparam ST_FETCH = 1'b1;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [1:0] mode_q;
    reg [1:0] mode_d;
    reg st_q;
    reg st_d;
    reg [2:0] pend_idx_q;
    reg [15:0] pend_sel_q;

    reg [15:0] seg_sel_q [0:5];
    reg [63:0] seg_base_q [0:5];
    reg [31:0] seg_limit_q [0:5];
    reg [11:0] seg_attr_q [0:5];

    reg [63:0] sys_base_q [0:3];
    reg [31:0] sys_limit_q [0:3];
    reg [15:0] local_sel_q;
    reg [15:0] task_sel_q;

    wire real_like;
    wire cs_wide;
    wire flat64;
    wire [2:0] ld_idx;
    wire ld_take;
    wire ld_bad_idx;
    wire use_local;
    wire [63:0] dtab_base;
    wire [31:0] dtab_limit;
    wire [63:0] desc_addr;
    wire desc_oob;
    wire [2:0] vec_shift;
    wire [63:0] vec_addr;
    wire vec_oob;
    wire acc_bad_idx;
    wire [2:0] acc_idx;
    wire [63:0] lin_addr;
    wire lin_fault;

    // ------------------------------------------------------------
    // mode
    // ------------------------------------------------------------
    assign real_like = (mode_q == `SAT_MODE_REAL) || (mode_q == `SAT_MODE_V86);
    assign cs_wide = seg_attr_q[`SAT_SEG_CODE][`SAT_ATTR_L_BIT];
    assign flat64 = (mode_q == `SAT_MODE_LONG) && cs_wide;
    assign mode_o = mode_q;
    assign mode_64_o = flat64;
    assign cpl_o = real_like ? 2'h0 :
        seg_attr_q[`SAT_SEG_CODE][`SAT_ATTR_DPL_MSB:`SAT_ATTR_DPL_LSB];
    assign def_opsize_o = seg_attr_q[`SAT_SEG_CODE][`SAT_ATTR_D_BIT];

    always @* begin
        mode_d = mode_q;
        if (intr_i && (mode_q == `SAT_MODE_V86)) begin
            mode_d = `SAT_MODE_PROT;
        end else if (mode_set_valid_i) begin
            if ((mode_set_i == `SAT_MODE_REAL) || (mode_set_i == `SAT_MODE_PROT)) begin
                mode_d = mode_set_i;
            end else if (mode_q != `SAT_MODE_REAL) begin
                mode_d = mode_set_i;
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_q <= `SAT_MODE_REAL;
            mode_err_o <= 1'b0;
        end else begin
            mode_q <= mode_d;
            // v86 and long mode only reachable from a mode other than real
            mode_err_o <= mode_set_valid_i && !(intr_i && (mode_q == `SAT_MODE_V86)) &&
                (mode_q == `SAT_MODE_REAL) &&
                ((mode_set_i == `SAT_MODE_V86) || (mode_set_i == `SAT_MODE_LONG));
        end
    end

    // ------------------------------------------------------------
    // descriptor lookup
    // ------------------------------------------------------------
    assign ld_idx = seg_ld_far_i ? `SAT_SEG_CODE : seg_ld_idx_i;
    assign ld_bad_idx = !seg_ld_far_i && (seg_ld_idx_i > `SAT_SEG_AUXG);
    assign seg_ld_ready_o = (st_q == ST_IDLE);
    assign ld_take = seg_ld_valid_i && (st_q == ST_IDLE);
    assign use_local = seg_ld_sel_i[`SAT_SEL_TABLE_BIT];
    assign dtab_base = use_local ? sys_base_q[`SAT_SYS_LOCAL] : sys_base_q[`SAT_SYS_GLOBAL];
    assign dtab_limit = use_local ? sys_limit_q[`SAT_SYS_LOCAL] :
        sys_limit_q[`SAT_SYS_GLOBAL];

    sat_desc_addr u_desc_addr (
        .tbl_base_i(dtab_base),
        .tbl_limit_i(dtab_limit),
        .index_i(seg_ld_sel_i[`SAT_SEL_INDEX_MSB:`SAT_SEL_INDEX_LSB]),
        .entry_shift_i(`SAT_DESC_SHIFT),
        .addr_o(desc_addr),
        .oob_o(desc_oob)
    );

    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                // real-like modes never start a table fetch
                if (ld_take && !real_like && !ld_bad_idx && !desc_oob) begin
                    st_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (desc_rsp_valid_i) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            pend_idx_q <= 3'h0;
            pend_sel_q <= 16'h0;
            desc_req_valid_o <= 1'b0;
            desc_req_addr_o <= 64'h0;
            seg_ld_fault_o <= 1'b0;
        end else begin
            st_q <= st_d;
            desc_req_valid_o <= 1'b0;
            seg_ld_fault_o <= ld_take && (ld_bad_idx || (!real_like && desc_oob));
            if (ld_take && (st_d == ST_FETCH)) begin
                pend_idx_q <= ld_idx;
                pend_sel_q <= seg_ld_sel_i;
                desc_req_valid_o <= 1'b1;
                desc_req_addr_o <= desc_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // user segment registers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SAT_SEG_COUNT; gi = gi + 1) begin : g_seg
            wire real_wr;
            wire desc_wr;
            wire aux_wr;
            assign real_wr = ld_take && real_like && !ld_bad_idx && (ld_idx == gi);
            assign desc_wr = (st_q == ST_FETCH) && desc_rsp_valid_i && (pend_idx_q == gi);
            assign aux_wr = aux_base_wr_valid_i && is_aux(gi) &&
                (aux_base_wr_g_i == (gi == `SAT_SEG_AUXG));
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    seg_sel_q[gi] <= `SAT_RST_SEL;
                    seg_base_q[gi] <= `SAT_RST_BASE;
                    seg_limit_q[gi] <= `SAT_RST_LIMIT;
                    seg_attr_q[gi] <= `SAT_RST_ATTR;
                end else if (real_wr) begin
                    // limit and attributes kept
                    seg_sel_q[gi] <= seg_ld_sel_i;
                    seg_base_q[gi] <= real_base(seg_ld_sel_i);
                end else if (desc_wr) begin
                    seg_sel_q[gi] <= pend_sel_q;
                    seg_base_q[gi] <= {32'h0, desc_rsp_base_i};
                    seg_limit_q[gi] <= desc_rsp_limit_i;
                    seg_attr_q[gi] <= desc_rsp_attr_i;
                end else if (aux_wr) begin
                    seg_base_q[gi] <= aux_base_wr_data_i;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // system segment registers
    // ------------------------------------------------------------
    genvar si;
    generate
        for (si = 0; si < 4; si = si + 1) begin : g_sys
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    sys_base_q[si] <= `SAT_RST_BASE;
                    sys_limit_q[si] <= `SAT_RST_TBL_LIMIT;
                end else if (sys_wr_valid_i && (sys_wr_sel_i == si)) begin
                    sys_base_q[si] <= sys_wr_base_i;
                    sys_limit_q[si] <= sys_wr_limit_i;
                end
            end
        end
    endgenerate

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            local_sel_q <= 16'h0;
            task_sel_q <= 16'h0;
        end else if (sys_wr_valid_i) begin
            if (sys_wr_sel_i == `SAT_SYS_LOCAL) begin
                local_sel_q <= sys_wr_selector_i;
            end else if (sys_wr_sel_i == `SAT_SYS_TASK) begin
                task_sel_q <= sys_wr_selector_i;
            end
        end
    end

    assign task_base_o = sys_base_q[`SAT_SYS_TASK];
    assign task_limit_o = sys_limit_q[`SAT_SYS_TASK];
    assign task_sel_o = task_sel_q;
    assign local_sel_o = local_sel_q;

    // ------------------------------------------------------------
    // vector table lookup
    // ------------------------------------------------------------
    assign vec_shift = (mode_q == `SAT_MODE_REAL) ? `SAT_VEC_SHIFT_REAL :
        ((mode_q == `SAT_MODE_LONG) ? `SAT_VEC_SHIFT_LONG : `SAT_VEC_SHIFT_PROT);

    sat_desc_addr u_vec_addr (
        .tbl_base_i(sys_base_q[`SAT_SYS_VECTOR]),
        .tbl_limit_i(sys_limit_q[`SAT_SYS_VECTOR]),
        .index_i({5'h0, vec_i}),
        .entry_shift_i(vec_shift),
        .addr_o(vec_addr),
        .oob_o(vec_oob)
    );

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            vec_rsp_valid_o <= 1'b0;
            vec_addr_o <= 64'h0;
            vec_fault_o <= 1'b0;
        end else begin
            vec_rsp_valid_o <= vec_valid_i;
            if (vec_valid_i) begin
                vec_addr_o <= vec_addr;
                vec_fault_o <= vec_oob;
            end
        end
    end

    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    assign acc_bad_idx = acc_seg_i > `SAT_SEG_AUXG;
    assign acc_idx = acc_bad_idx ? `SAT_SEG_DEFDATA : acc_seg_i;

    sat_lin_addr u_lin_addr (
        .real_i(real_like),
        .flat64_i(flat64),
        .keep_base_i(is_aux(acc_idx)),
        .base_i(seg_base_q[acc_idx]),
        .limit_i(seg_limit_q[acc_idx]),
        .off_i(acc_off_i),
        .addr_o(lin_addr),
        .fault_o(lin_fault)
    );

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_valid_o <= 1'b0;
            acc_addr_o <= 64'h0;
            acc_fault_o <= 1'b0;
        end else begin
            acc_valid_o <= acc_valid_i;
            if (acc_valid_i) begin
                acc_addr_o <= lin_addr;
                acc_fault_o <= lin_fault || acc_bad_idx;
            end
        end
    end

endmodule
`default_nettype wire

/* File: dv/sat_seg_xlate_chk.sv */
// assertion checker for the segment translation top
`timescale 1ns/100ps
`default_nettype none
`include "sat_defs.vh"
module sat_seg_xlate_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic intr_i,
    input wire logic [1:0] mode_o,
    input wire logic mode_64_o,
    input wire logic seg_ld_valid_i,
    input wire logic [15:0] seg_ld_sel_i,
    input wire logic seg_ld_ready_o,
    input wire logic desc_req_valid_o,
    input wire logic [63:0] desc_req_addr_o,
    input wire logic desc_rsp_valid_i,
    input wire logic sys_wr_valid_i,
    input wire logic [1:0] sys_wr_sel_i,
    input wire logic [63:0] sys_wr_base_i,
    input wire logic acc_valid_i,
    input wire logic [2:0] acc_seg_i,
    input wire logic [63:0] acc_off_i,
    input wire logic acc_valid_o,
    input wire logic [63:0] acc_addr_o,
    input wire logic acc_fault_o
);
    logic [63:0] gb_q;
    logic [63:0] lb_q;
    wire rm = mode_o == `SAT_MODE_REAL || mode_o == `SAT_MODE_V86;
    wire cm = mode_o == `SAT_MODE_PROT || (mode_o == `SAT_MODE_LONG && !mode_64_o);
    wire lm = mode_o == `SAT_MODE_LONG && mode_64_o;
    wire [63:0] ent = (seg_ld_sel_i[2] ? lb_q : gb_q) + {48'h0, seg_ld_sel_i[15:3], 3'h0};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // --------
    // table base shadows and properties
    // --------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            gb_q <= 64'h0;
            lb_q <= 64'h0;
        end else if (sys_wr_valid_i && sys_wr_sel_i == `SAT_SYS_GLOBAL)
            gb_q <= sys_wr_base_i;
        else if (sys_wr_valid_i && sys_wr_sel_i == `SAT_SYS_LOCAL)
            lb_q <= sys_wr_base_i;
    end
    sequence s_take;
        !rm && seg_ld_valid_i && seg_ld_ready_o;
    endsequence
    sequence s_fetch;
        s_take ##1 desc_req_valid_o;
    endsequence
    a_reset_real: assert property ($fell(rst_i) |-> mode_o == `SAT_MODE_REAL)
        else $error("not real after reset");
    a_real_nofetch: assert property (rm && seg_ld_valid_i && seg_ld_ready_o |=>
        !desc_req_valid_o) else $error("real mode fetch");
    a_real_span: assert property (rm && acc_valid_i && acc_seg_i < 3'h6 |=> acc_valid_o &&
        !acc_fault_o && acc_addr_o[63:20] == 44'h0) else $error("real address too wide");
    a_v86_intr: assert property (mode_o == `SAT_MODE_V86 && intr_i |=> mode_o == `SAT_MODE_PROT)
        else $error("v86 interrupt missed");
    a_desc_addr: assert property (s_fetch |-> !seg_ld_ready_o &&
        desc_req_addr_o == $past(ent)) else $error("bad descriptor address");
    a_rsp_release: assert property (!seg_ld_ready_o && desc_rsp_valid_i |=> seg_ld_ready_o)
        else $error("ready stuck low");
    a_flat_64: assert property (lm && acc_valid_i && acc_seg_i < 3'h4 |=>
        acc_addr_o == $past(acc_off_i) && !acc_fault_o) else $error("64-bit not flat");
    a_compat_low: assert property (cm && acc_valid_i |=> acc_fault_o || acc_addr_o[63:32] == 32'h0)
        else $error("address above 4G");
endmodule
bind sat_seg_xlate sat_seg_xlate_chk u_chk (.*);
`default_nettype wire

/* File: dv/sat_desc_mem.sv */
// descriptor memory model answering table fetches
`timescale 1ns/100ps
`default_nettype none
module sat_desc_mem (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic [63:0] req_addr_i,
    input wire logic [3:0] delay_i,
    input wire logic flat_i,
    input wire logic [11:0] attr_i,
    output logic rsp_valid_o,
    output logic [31:0] rsp_base_o,
    output logic [31:0] rsp_limit_o,
    output logic [11:0] rsp_attr_o
);
    logic pend_q;
    logic [3:0] cnt_q;
    logic [31:0] base_q;
    logic [31:0] lim_q;
    logic [11:0] attr_q;
    // --------
    // delayed answer, fields inverted when idle
    // --------
    assign rsp_base_o = rsp_valid_o ? base_q : ~base_q;
    assign rsp_limit_o = rsp_valid_o ? lim_q : ~lim_q;
    assign rsp_attr_o = rsp_valid_o ? attr_q : ~attr_q;
    always @(posedge core_clk_i) begin
        rsp_valid_o <= 1'b0;
        if (rst_i)
            pend_q <= 1'b0;
        else if (req_valid_i) begin
            pend_q <= 1'b1;
            cnt_q <= delay_i;
            base_q <= flat_i ? 32'h0 : req_addr_i[31:0] + 32'h0001_0000;
            lim_q <= flat_i ? 32'hffff_ffff : 32'h0000_0fff;
            attr_q <= attr_i;
        end else if (pend_q) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q <= 4'h1) begin
                pend_q <= 1'b0;
                rsp_valid_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/sat_seg_xlate_bench.sv */
// self-checking bench for the segment translation top
`timescale 1ns/100ps
`default_nettype none
`include "sat_defs.vh"
module sat_seg_xlate_bench;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ms_v = 0, intr = 0, ld_v = 0, far = 0, aux_v = 0, aux_g = 0, sys_v = 0, vec_v = 0;
    logic acc_v = 0, flat = 0, f, m64, opsz, merr, rdy, lflt, req_v, rsp_v, vrv, vflt, arv, aflt;
    logic [1:0] ms = 0, sys_s = 0, mode, cpl;
    logic [2:0] ld_i = 0, acc_s = 0;
    logic [3:0] dly = 4'h1;
    logic [7:0] vec = 0;
    logic [11:0] attr = 12'h093, ra;
    logic [15:0] ld_s = 0, sys_sel = 0, tsel, lsel;
    logic [31:0] sys_l = 0, rb, rl, tlim;
    logic [63:0] aux_d = 0, sys_b = 0, acc_o = 0, req_a, tbase, vaddr, aaddr;
    int err_count = 0;
    int checked = 0;
    sat_seg_xlate dut (
        .core_clk_i, .rst_i, .mode_set_valid_i(ms_v), .mode_set_i(ms),
        .intr_i(intr), .mode_o(mode), .mode_64_o(m64), .cpl_o(cpl), .def_opsize_o(opsz),
        .mode_err_o(merr), .seg_ld_valid_i(ld_v), .seg_ld_idx_i(ld_i), .seg_ld_far_i(far),
        .seg_ld_sel_i(ld_s), .seg_ld_ready_o(rdy), .seg_ld_fault_o(lflt),
        .desc_req_valid_o(req_v), .desc_req_addr_o(req_a), .desc_rsp_valid_i(rsp_v),
        .desc_rsp_base_i(rb), .desc_rsp_limit_i(rl), .desc_rsp_attr_i(ra),
        .aux_base_wr_valid_i(aux_v), .aux_base_wr_g_i(aux_g), .aux_base_wr_data_i(aux_d),
        .sys_wr_valid_i(sys_v), .sys_wr_sel_i(sys_s), .sys_wr_base_i(sys_b),
        .sys_wr_limit_i(sys_l), .sys_wr_selector_i(sys_sel), .task_base_o(tbase),
        .task_limit_o(tlim), .task_sel_o(tsel), .local_sel_o(lsel), .vec_valid_i(vec_v),
        .vec_i(vec), .vec_rsp_valid_o(vrv), .vec_addr_o(vaddr), .vec_fault_o(vflt),
        .acc_valid_i(acc_v), .acc_seg_i(acc_s), .acc_off_i(acc_o), .acc_valid_o(arv),
        .acc_addr_o(aaddr), .acc_fault_o(aflt)
    );
    sat_desc_mem mem (
        .core_clk_i, .rst_i, .req_valid_i(req_v), .req_addr_i(req_a),
        .delay_i(dly), .flat_i(flat), .attr_i(attr), .rsp_valid_o(rsp_v), .rsp_base_o(rb),
        .rsp_limit_o(rl), .rsp_attr_o(ra)
    );
    always #2 core_clk_i = ~core_clk_i;
    // --------
    // stimulus and check tasks
    // --------
    task automatic chk(input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic md(input logic [1:0] m);
        @(negedge core_clk_i) ms_v = 1'b1;
        ms = m;
        @(negedge core_clk_i) ms_v = 1'b0;
    endtask
    task automatic ld(input logic [2:0] i, input logic fa, input logic [15:0] s);
        int n = 0;
        @(negedge core_clk_i) ld_v = 1'b1;
        ld_i = i;
        far = fa;
        ld_s = s;
        @(negedge core_clk_i) ld_v = 1'b0;
        f = lflt;
        while (!rdy && n < 40) @(negedge core_clk_i) n++;
        chk(n < 40, 1'b1);
    endtask
    task automatic ac(input logic [2:0] s, input logic [63:0] o, ea, input logic ef);
        @(negedge core_clk_i) acc_v = 1'b1;
        acc_s = s;
        acc_o = o;
        @(negedge core_clk_i) acc_v = 1'b0;
        chk(arv, 1'b1);
        chk(aflt, ef);
        if (!ef) chk(aaddr, ea);
    endtask
    task automatic sw(input logic [1:0] s, input logic [63:0] b, input logic [31:0] l,
                      input logic [15:0] sl);
        @(negedge core_clk_i) sys_v = 1'b1;
        sys_s = s;
        sys_b = b;
        sys_l = l;
        sys_sel = sl;
        @(negedge core_clk_i) sys_v = 1'b0;
    endtask
    task automatic vc(input logic [7:0] v, input logic [63:0] ea, input logic ef);
        @(negedge core_clk_i) vec_v = 1'b1;
        vec = v;
        @(negedge core_clk_i) vec_v = 1'b0;
        chk(vrv, 1'b1);
        chk(vflt, ef);
        if (!ef) chk(vaddr, ea);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(4 * 2000);
        err_count++;
        conclude();
    end
    initial begin
        repeat (3) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk(mode, `SAT_MODE_REAL);
        chk(tlim, 32'h0000_ffff);
        md(`SAT_MODE_V86);
        chk({merr, mode}, {1'b1, `SAT_MODE_REAL});
        ld(3'h3, 0, 16'h1234);
        ac(3'h3, 64'hffff, 64'h2233f, 0);
        ld(3'h3, 1, 16'hf000);
        ac(3'h1, 64'hfff0, 64'hffff0, 0);
        ac(3'h3, 64'h0, 64'h12340, 0);
        ld(3'h0, 0, 16'hffff);
        ac(3'h0, 64'h1_0011, 64'h1, 0);
        sw(2'h2, 64'h400, 32'h3ff, 16'h0);
        vc(8'h10, 64'h440, 0);
        md(`SAT_MODE_PROT);
        chk(mode, `SAT_MODE_PROT);
        sw(2'h0, 64'h2000, 32'h00ff, 16'h0);
        sw(2'h1, 64'h8000, 32'hffff, 16'h0030);
        chk(lsel, 16'h0030);
        dly = 4'h5;
        ld(3'h2, 0, 16'h0010);
        ac(3'h2, 64'hfff, 64'h1300f, 0);
        ac(3'h2, 64'h1000, 64'h0, 1);
        dly = 4'h1;
        ld(3'h0, 0, 16'h000c);
        ac(3'h0, 64'h8, 64'h18010, 0);
        ld(3'h3, 0, 16'h0100);
        chk(f, 1);
        ld(3'h3, 0, 16'h00f8);
        ac(3'h3, 64'h0, 64'h120f8, 0);
        vc(8'h7f, 64'h7f8, 0);
        vc(8'h80, 64'h0, 1);
        flat = 1'b1;
        ld(3'h3, 0, 16'h0018);
        ac(3'h3, 64'hffff_fff0, 64'hffff_fff0, 0);
        ac(3'h3, 64'h1_0000_0000, 64'h0, 1);
        flat = 1'b0;
        ac(3'h6, 64'h0, 64'h0, 1);
        md(`SAT_MODE_V86);
        ld(3'h0, 0, 16'h0100);
        ac(3'h0, 64'h20, 64'h1020, 0);
        @(negedge core_clk_i) intr = 1'b1;
        @(negedge core_clk_i) intr = 1'b0;
        chk(mode, `SAT_MODE_PROT);
        attr = 12'h26b;
        ld(3'h1, 1, 16'h0008);
        md(`SAT_MODE_LONG);
        chk({m64, cpl, opsz}, 4'he);
        ac(3'h1, 64'hffff_8000_0000_1234, 64'hffff_8000_0000_1234, 0);
        @(negedge core_clk_i) aux_v = 1'b1;
        aux_g = 1'b1;
        aux_d = 64'h7fff_0000_0000_0000;
        @(negedge core_clk_i) aux_v = 1'b0;
        ac(3'h5, 64'h10, 64'h7fff_0000_0000_0010, 0);
        sw(2'h3, 64'habc0_0000_0000, 32'h67, 16'h0028);
        chk({tbase, tlim, tsel}, {64'habc0_0000_0000, 32'h67, 16'h0028});
        vc(8'h3f, 64'h7f0, 0);
        vc(8'h40, 64'h0, 1);
        attr = 12'h49b;
        ld(3'h1, 1, 16'h0008);
        chk({m64, opsz}, 2'h1);
        ac(3'h2, 64'h1000, 64'h0, 1);
        ac(3'h2, 64'h10, 64'h12020, 0);
        conclude();
    end
endmodule
`default_nettype wire
